/* File: twmsp_pkg.sv */
package twmsp_pkg;

  // Bus timing at the reference clock
  localparam int unsigned REF_CLK_MHZ = 125;
  localparam int unsigned SCL_HALF_NS = 500;
  localparam int unsigned SCL_HALF_CYC = (SCL_HALF_NS * REF_CLK_MHZ + 999) / 1000;
  localparam logic [6:0] SCL_HALF_LD = 7'(SCL_HALF_CYC);
  localparam logic [6:0] SDA_SET_PT = 7'(SCL_HALF_CYC / 2);

  // Bit positions within a byte slot
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_DONE = 4'h9;

  // Receive buffer shape
  localparam int unsigned FIFO_WIDTH = 8;
  localparam int unsigned FIFO_DEPTH = 16;

  // Master command codes
  typedef enum logic [1:0] {OP_START, OP_WRITE, OP_READ, OP_STOP} twmsp_op_t;

  typedef struct packed {
    twmsp_op_t op;
    logic [7:0] data;
    logic nack;
  } twmsp_cmd_t;

  typedef struct packed {
    logic slave_en;
    logic master_en;
    logic irq_en;
    logic [6:0] own_addr;
  } twmsp_cfg_t;

  typedef struct packed {
    logic start_seen;
    logic stop_seen;
    logic addr_hit;
    logic byte_done;
    logic nack_seen;
    logic arb_lost;
    logic cmd_err;
  } twmsp_evt_t;

  typedef struct packed {
    logic bus_busy;
    logic master_own;
    logic slave_sel;
    logic slave_read;
  } twmsp_stat_t;

endpackage

/* File: twmsp_fifo.sv */
`timescale 1ns/1ps
module twmsp_fifo #(
  parameter int unsigned WIDTH = twmsp_pkg::FIFO_WIDTH,
  parameter int unsigned DEPTH = twmsp_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic [AW:0] count_nxt;
  logic push;
  logic pop;

  // Flags are registered so both sides see clean levels
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_r[rd_ptr_r];

  always_comb begin
    count_nxt = count_r;
    if (push && !pop) count_nxt = count_r + (AW + 1)'(1);
    else if (pop && !push) count_nxt = count_r - (AW + 1)'(1);
  end

  // Pointers and flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + AW'(1);
      if (pop) rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + AW'(1);
      count_r <= count_nxt;
      in_ready <= (count_nxt != FULL_CNT);
      out_valid <= (count_nxt != '0);
    end
  end

  // Storage, no reset needed
  always_ff @(posedge clk) begin
    if (push) mem_r[wr_ptr_r] <= in_data;
  end

endmodule // twmsp_fifo

/* File: twmsp_top.sv */
`timescale 1ns/1ps
module twmsp_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Configuration
  input wire twmsp_pkg::twmsp_cfg_t cfg,
  // Bus pins, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Master commands
  input wire logic cmd_valid,
  input wire twmsp_pkg::twmsp_cmd_t cmd,
  output logic cmd_ready,
  // Slave transmit bytes
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  // Received bytes
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  // Events and status
  output twmsp_pkg::twmsp_evt_t evt,
  output twmsp_pkg::twmsp_stat_t stat,
  output logic irq,
  output logic wake
);
  typedef enum logic [2:0] {SL_IDLE, SL_ADDR, SL_RX, SL_TX, SL_TXWAIT, SL_SKIP} twmsp_sl_t;
  typedef enum logic [3:0] {
    M_IDLE, M_HOLD, M_RS1, M_START1, M_START2, M_BIT_LO, M_BIT_HI, M_STOP1, M_STOP2, M_STOP3
  } twmsp_ms_t;

  logic rst_meta_r, rst_n_r;
  logic scl_meta_r, scl_s_r, scl_d_r, sda_meta_r, sda_s_r, sda_d_r;
  logic busy_r;
  twmsp_sl_t s_state_r;
  logic [3:0] s_cnt_r;
  logic [7:0] s_sh_r, s_tx_r;
  logic s_sda_low_r, s_sel_r, s_read_r, s_nack_r, s_hold_r;
  twmsp_ms_t m_state_r;
  logic [6:0] m_tmr_r;
  logic [3:0] m_cnt_r;
  logic [7:0] m_sh_r, m_rx_r;
  logic m_tx_r, m_nack_r, m_bit_r, m_last_r, m_own_r, m_scl_low_r, m_sda_low_r, m_hi_seen_r;
  logic m_ack_r, cmd_ready_r, tx_ready_r, push_r, fifo_in_ready;
  logic [7:0] push_data_r;
  twmsp_pkg::twmsp_evt_t evt_nxt, evt_r;
  twmsp_pkg::twmsp_stat_t stat_r;
  logic irq_r, wake_r, scl_oe_r, sda_oe_r;

  // Reset release through two flops
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // Pin synchronisers; idle bus reads high
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      {scl_meta_r, scl_s_r, scl_d_r} <= 3'h7;
      {sda_meta_r, sda_s_r, sda_d_r} <= 3'h7;
    end else begin
      scl_meta_r <= scl_i;
      scl_s_r <= scl_meta_r;
      scl_d_r <= scl_s_r;
      sda_meta_r <= sda_i;
      sda_s_r <= sda_meta_r;
      sda_d_r <= sda_s_r;
    end
  end

  // Framing detection on the synchronised copies
  wire scl_rise = scl_s_r && !scl_d_r;
  wire scl_fall = scl_d_r && !scl_s_r;
  wire start_det = scl_s_r && scl_d_r && sda_d_r && !sda_s_r;
  wire stop_det = scl_s_r && scl_d_r && !sda_d_r && sda_s_r;
  wire [7:0] s_byte_w = {s_sh_r[6:0], sda_s_r};
  wire s_hit_w = (s_state_r == SL_ADDR) && scl_rise && (s_cnt_r == twmsp_pkg::BIT_LAST)
    && cfg.slave_en && !m_own_r && (s_byte_w[7:1] == cfg.own_addr);
  wire s_push_w = (s_state_r == SL_RX) && scl_rise && (s_cnt_r == twmsp_pkg::BIT_LAST);
  wire s_done_w = ((s_state_r == SL_RX) || (s_state_r == SL_TX)) && scl_rise
    && (s_cnt_r == twmsp_pkg::BIT_ACK);
  wire tx_take = tx_ready_r && tx_valid;

  // Bus busy between start and stop
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) busy_r <= 1'b0;
    else if (start_det) busy_r <= 1'b1;
    else if (stop_det) busy_r <= 1'b0;
  end

  // Slave engine, paced by edges seen on the bus
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      s_state_r <= SL_IDLE;
      s_cnt_r <= 4'h0;
      s_sh_r <= 8'h00;
      s_tx_r <= 8'h00;
      s_sda_low_r <= 1'b0;
      s_sel_r <= 1'b0;
      s_read_r <= 1'b0;
      s_nack_r <= 1'b0;
    end else if (stop_det) begin
      s_state_r <= SL_IDLE;
      s_sda_low_r <= 1'b0;
      s_sel_r <= 1'b0;
    end else if (start_det) begin
      s_state_r <= SL_ADDR;
      s_cnt_r <= 4'h0;
      s_sda_low_r <= 1'b0;
      s_sel_r <= 1'b0;
      s_read_r <= 1'b0;
    end else begin
      unique case (s_state_r)
        SL_IDLE, SL_SKIP: begin
        end
        SL_TXWAIT: begin
          if (tx_take) begin
            s_tx_r <= tx_data;
            s_sda_low_r <= ~tx_data[7];
            s_cnt_r <= 4'h0;
            s_state_r <= SL_TX;
          end
        end
        SL_ADDR, SL_RX, SL_TX: begin
          if (scl_rise) begin
            if (s_cnt_r < twmsp_pkg::BIT_ACK) s_sh_r <= s_byte_w;
            if (s_cnt_r == twmsp_pkg::BIT_ACK) s_nack_r <= sda_s_r;
            if (s_cnt_r != twmsp_pkg::BIT_DONE) s_cnt_r <= s_cnt_r + 4'h1;
            if ((s_state_r == SL_ADDR) && (s_cnt_r == twmsp_pkg::BIT_LAST)) begin
              // Ten-bit headers are matched like any seven-bit value
              if (s_hit_w) begin
                s_sel_r <= 1'b1;
                s_read_r <= s_byte_w[0];
              end else begin
                s_state_r <= SL_SKIP;
              end
            end
          end else if (scl_fall) begin
            if (s_cnt_r == twmsp_pkg::BIT_ACK) begin
              s_sda_low_r <= (s_state_r != SL_TX);
            end else if (s_cnt_r == twmsp_pkg::BIT_DONE) begin
              s_sda_low_r <= 1'b0;
              s_cnt_r <= 4'h0;
              if (s_state_r == SL_ADDR) s_state_r <= s_read_r ? SL_TXWAIT : SL_RX;
              else if (s_state_r == SL_TX) s_state_r <= s_nack_r ? SL_SKIP : SL_TXWAIT;
            end else if ((s_state_r == SL_TX) && (s_cnt_r != 4'h0)) begin
              s_sda_low_r <= ~s_tx_r[3'(twmsp_pkg::BIT_LAST - s_cnt_r)];
            end
          end
        end
        default: s_state_r <= SL_IDLE;
      endcase
    end
  end

  // Slave clock stretch while waiting for data or buffer room
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      s_hold_r <= 1'b0;
      tx_ready_r <= 1'b0;
    end else begin
      // Hold through the load cycle so data settles before the clock is freed
      s_hold_r <= (s_state_r == SL_TXWAIT) ||
        (push_r && (s_state_r == SL_RX) && (s_cnt_r == twmsp_pkg::BIT_ACK) && !scl_s_r);
      tx_ready_r <= (s_state_r == SL_TXWAIT) && !tx_take && !start_det && !stop_det;
    end
  end

  // Master strobes
  wire take_w = cmd_valid && cmd_ready_r;
  wire m_hi_end_w = (m_state_r == M_BIT_HI) &&
    ((scl_s_r && (m_tmr_r == 7'h00)) || (m_hi_seen_r && !scl_s_r));
  wire m_lost_w = (m_state_r == M_BIT_HI) && m_tx_r && (m_cnt_r < twmsp_pkg::BIT_ACK)
    && scl_s_r && !m_sda_low_r && !sda_s_r;
  wire m_byte_w = m_hi_end_w && !m_lost_w && (m_cnt_r == twmsp_pkg::BIT_ACK);
  wire m_err_w = take_w && (m_state_r == M_IDLE) && (cmd.op != twmsp_pkg::OP_START);

  // Master command readiness; waits out a pending buffer write
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) cmd_ready_r <= 1'b0;
    else cmd_ready_r <= !take_w && !push_r && cfg.master_en &&
      ((m_state_r == M_HOLD) || ((m_state_r == M_IDLE) && !busy_r));
  end

  // Master sequencer; data changes only mid-low to avoid false framing
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      m_state_r <= M_IDLE;
      m_tmr_r <= 7'h00;
      m_cnt_r <= 4'h0;
      m_sh_r <= 8'h00;
      m_rx_r <= 8'h00;
      {m_tx_r, m_nack_r, m_bit_r, m_last_r, m_ack_r, m_hi_seen_r} <= 6'h00;
      {m_own_r, m_scl_low_r, m_sda_low_r} <= 3'h0;
    end else begin
      unique case (m_state_r)
        M_IDLE: begin
          if (take_w && (cmd.op == twmsp_pkg::OP_START)) begin
            m_sda_low_r <= 1'b1;
            m_own_r <= 1'b1;
            m_tmr_r <= twmsp_pkg::SCL_HALF_LD;
            m_state_r <= M_START2;
          end
        end
        M_HOLD: begin
          if (take_w) begin
            m_tmr_r <= twmsp_pkg::SCL_HALF_LD;
            m_cnt_r <= 4'h0;
            m_last_r <= 1'b0;
            unique case (cmd.op)
              twmsp_pkg::OP_START: begin
                m_sda_low_r <= 1'b0;
                m_state_r <= M_RS1;
              end
              twmsp_pkg::OP_WRITE: begin
                m_sh_r <= cmd.data;
                m_bit_r <= ~cmd.data[7];
                m_tx_r <= 1'b1;
                m_state_r <= M_BIT_LO;
              end
              twmsp_pkg::OP_READ: begin
                m_bit_r <= 1'b0;
                m_tx_r <= 1'b0;
                m_nack_r <= cmd.nack;
                m_state_r <= M_BIT_LO;
              end
              twmsp_pkg::OP_STOP: begin
                m_sda_low_r <= 1'b1;
                m_state_r <= M_STOP1;
              end
            endcase
          end
        end
        M_RS1, M_START2, M_STOP1, M_STOP3, M_BIT_LO: begin
          m_tmr_r <= m_tmr_r - 7'h01;
          if ((m_state_r == M_BIT_LO) && (m_tmr_r == twmsp_pkg::SDA_SET_PT)) m_sda_low_r <= m_bit_r;
          if (m_tmr_r == 7'h00) begin
            m_tmr_r <= twmsp_pkg::SCL_HALF_LD;
            m_hi_seen_r <= 1'b0;
            unique case (m_state_r)
              M_RS1: m_state_r <= M_START1;
              M_START2: m_state_r <= M_HOLD;
              M_STOP1: m_state_r <= M_STOP2;
              M_STOP3: m_state_r <= M_IDLE;
              default: m_state_r <= m_last_r ? M_HOLD : M_BIT_HI;
            endcase
            m_scl_low_r <= (m_state_r == M_START2) || ((m_state_r == M_BIT_LO) && m_last_r);
            if (m_state_r == M_STOP3) m_own_r <= 1'b0;
          end
        end
        M_START1, M_STOP2: begin
          // High phase counts only while the wire is really high
          if (scl_s_r) m_tmr_r <= m_tmr_r - 7'h01;
          if (scl_s_r && (m_tmr_r == 7'h00)) begin
            m_tmr_r <= twmsp_pkg::SCL_HALF_LD;
            m_sda_low_r <= (m_state_r == M_START1);
            m_state_r <= (m_state_r == M_START1) ? M_START2 : M_STOP3;
          end
        end
        M_BIT_HI: begin
          if (m_lost_w) begin
            {m_own_r, m_scl_low_r, m_sda_low_r} <= 3'h0;
            m_state_r <= M_IDLE;
          end else if (m_hi_end_w) begin
            m_scl_low_r <= 1'b1;
            m_tmr_r <= twmsp_pkg::SCL_HALF_LD;
            m_cnt_r <= m_cnt_r + 4'h1;
            m_state_r <= M_BIT_LO;
            if (m_cnt_r < twmsp_pkg::BIT_ACK) m_rx_r <= {m_rx_r[6:0], sda_s_r};
            else m_ack_r <= !sda_s_r;
            if (m_cnt_r < 4'h7) begin
              m_sh_r <= {m_sh_r[6:0], 1'b0};
              m_bit_r <= m_tx_r && !m_sh_r[6];
            end else if (m_cnt_r == twmsp_pkg::BIT_LAST) begin
              m_bit_r <= !m_tx_r && !m_nack_r;
            end else begin
              m_bit_r <= 1'b0;
              m_last_r <= 1'b1;
            end
          end else if (scl_s_r) begin
            m_hi_seen_r <= 1'b1;
            if (m_tmr_r != 7'h00) m_tmr_r <= m_tmr_r - 7'h01;
          end
        end
        default: m_state_r <= M_IDLE;
      endcase
    end
  end

  // One write port into the buffer, held until accepted
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      push_r <= 1'b0;
      push_data_r <= 8'h00;
    end else if (s_push_w) begin
      push_r <= 1'b1;
      push_data_r <= s_byte_w;
    end else if (m_byte_w && !m_tx_r) begin
      push_r <= 1'b1;
      push_data_r <= m_rx_r;
    end else if (fifo_in_ready) begin
      push_r <= 1'b0;
    end
  end

  twmsp_fifo #(
    .WIDTH(twmsp_pkg::FIFO_WIDTH),
    .DEPTH(twmsp_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(ref_clk),
    .rst_n(rst_n_r),
    .in_valid(push_r),
    .in_data(push_data_r),
    .in_ready(fifo_in_ready),
    .out_valid(rx_valid),
    .out_data(rx_data),
    .out_ready(rx_ready)
  );

  // Event collection
  always_comb begin
    evt_nxt = '0;
    evt_nxt.start_seen = start_det && cfg.slave_en;
    evt_nxt.stop_seen = stop_det && cfg.slave_en;
    evt_nxt.addr_hit = s_hit_w;
    evt_nxt.byte_done = s_done_w || m_byte_w;
    evt_nxt.nack_seen = (s_done_w && (s_state_r == SL_TX) && sda_s_r) || (m_byte_w && m_tx_r && sda_s_r);
    evt_nxt.arb_lost = m_lost_w;
    evt_nxt.cmd_err = m_err_w;
  end

  // Output flops; interrupt only when selected, else poll
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      evt_r <= '0;
      stat_r <= '0;
      irq_r <= 1'b0;
      wake_r <= 1'b0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else begin
      evt_r <= evt_nxt;
      stat_r <= {busy_r, m_own_r, s_sel_r, s_read_r};
      irq_r <= cfg.irq_en && (|evt_nxt);
      wake_r <= s_hit_w;
      scl_oe_r <= m_scl_low_r || s_hold_r;
      sda_oe_r <= m_sda_low_r || s_sda_low_r;
    end
  end

  // Open drain: the pin level is only ever pulled low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = scl_oe_r;
  assign sda_oe = sda_oe_r;
  assign cmd_ready = cmd_ready_r;
  assign tx_ready = tx_ready_r;
  assign evt = evt_r;
  assign stat = stat_r;
  assign irq = irq_r;
  assign wake = wake_r;

  // Helper: length of each master low phase
  logic [7:0] lo_cnt_r;
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) lo_cnt_r <= 8'h00;
    else if (!m_scl_low_r) lo_cnt_r <= 8'h00;
    else if (lo_cnt_r != 8'hFF) lo_cnt_r <= lo_cnt_r + 8'h01;
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n_r);

  chk_start_silent: assert property (start_det && !cfg.slave_en |=> !evt_r.start_seen)
    else $error("start event raised with slave disabled");
  chk_start_listen: assert property (start_det && !stop_det |=> s_state_r == SL_ADDR)
    else $error("slave did not enter address phase after start");
  chk_addr_dir: assert property (s_hit_w |=> s_sel_r && (s_read_r == $past(sda_s_r)))
    else $error("direction bit not taken from eighth bit");
  chk_match_wake: assert property (s_hit_w |=> wake_r && evt_r.addr_hit ##1 !wake_r)
    else $error("wake pulse missing after address match");
  chk_nomatch_skip: assert property ((s_state_r == SL_ADDR) && scl_rise &&
    (s_cnt_r == twmsp_pkg::BIT_LAST) && (s_byte_w[7:1] != cfg.own_addr) |=> s_state_r == SL_SKIP)
    else $error("foreign address not ignored");
  chk_arb_release: assert property (m_lost_w |=> !m_own_r && !m_sda_low_r && !m_scl_low_r)
    else $error("bus not released after lost arbitration");
  chk_scl_low_min: assert property ($fell(m_scl_low_r) |-> lo_cnt_r >= 8'(twmsp_pkg::SCL_HALF_CYC))
    else $error("clock low phase too short");
  chk_rstart_seq: assert property ((m_state_r == M_HOLD) && take_w && (cmd.op == twmsp_pkg::OP_START)
    |=> m_own_r && m_scl_low_r && !m_sda_low_r)
    else $error("repeated start not begun with clock low");
  chk_stop_end: assert property ((m_state_r == M_STOP2) && scl_s_r && (m_tmr_r == 7'h00)
    |=> !m_sda_low_r ##[1:70] (m_state_r == M_IDLE) && !m_own_r)
    else $error("stop did not release the bus");
  chk_push_kept: assert property (push_r && !fifo_in_ready |=> push_r && $stable(push_data_r))
    else $error("received byte dropped under back-pressure");
  chk_irq_mode: assert property ((|evt_r) |-> irq_r == $past(cfg.irq_en))
    else $error("interrupt does not follow mode selection");
  chk_tx_load: assert property (tx_take && (s_state_r == SL_TXWAIT) && !start_det && !stop_det
    |=> (s_state_r == SL_TX) && (s_sda_low_r == !$past(tx_data[7])))
    else $error("slave transmit byte not loaded");

  cov_slave_hit: cover property (s_hit_w);
  cov_arb_lost: cover property (m_lost_w);
  cov_slave_stretch: cover property (s_hold_r && push_r);
  cov_master_read: cover property (m_byte_w && !m_tx_r);

endmodule // twmsp_top

/* File: twmsp_slave_model.sv */
`timescale 1ns/1ps
module twmsp_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  // Bus wires
  input wire logic scl,
  input wire logic sda,
  output logic sda_low,
  // Observed results
  output logic [7:0] last_byte,
  output logic got_stop
);
  int cnt;
  logic [7:0] sh;
  logic first;
  logic sel;
  // Idle, bus released
  initial begin
    sda_low = 1'b0;
    cnt = 10;
    sh = 8'h00;
    first = 1'b0;
    sel = 1'b0;
    last_byte = 8'h00;
    got_stop = 1'b0;
  end
  // Start or repeated start restarts the byte count
  always @(negedge sda) if (scl) begin
    cnt = 0;
    first = 1'b1;
    sel = 1'b0;
    got_stop = 1'b0;
  end
  // Stop frees the slave
  always @(posedge sda) if (scl) begin
    got_stop = 1'b1;
    sel = 1'b0;
    cnt = 10;
  end
  // Sample on rising clock, MSB first
  always @(posedge scl) if (cnt < 8) begin
    sh = {sh[6:0], sda};
    cnt = cnt + 1;
  end
  // Ack in ninth low phase; writes only, so never drives read data
  always @(negedge scl) begin
    if (cnt == 8) begin
      if (first) sel = (sh[7:1] == ADDR) && !sh[0];
      else if (sel) last_byte = sh;
      sda_low = sel;
      first = 1'b0;
      cnt = 9;
    end else if (cnt == 9) begin
      sda_low = 1'b0;
      cnt = 0;
    end
  end
endmodule // twmsp_slave_model

/* File: twmsp_tb_top.sv */
`timescale 1ns/1ps
module twmsp_tb_top;
  localparam logic [6:0] SLV_ADDR = 7'h2A;
  localparam logic [6:0] OWN_ADDR = 7'h33;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  twmsp_pkg::twmsp_cfg_t cfg = '0;
  logic cmd_valid = 1'b0;
  twmsp_pkg::twmsp_cmd_t cmd = '0;
  logic rx_ready = 1'b0;
  logic tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic tx_ready;
  twmsp_pkg::twmsp_stat_t stat;
  logic seen_clr = 1'b0;
  logic m_scl_low = 1'b0;
  logic m_sda_low = 1'b0;
  logic s_sda_low, scl_oe, sda_oe, cmd_ready, rx_valid, irq, wake, got_stop;
  logic [7:0] rx_data, last_byte;
  twmsp_pkg::twmsp_evt_t evt;
  logic [5:0] seen = '0;
  int n_errors = 0;
  int n_tests = 0;
  // Open drain with pull-up: any party pulling wins
  wire scl_w = !(scl_oe | m_scl_low);
  wire sda_w = !(sda_oe | m_sda_low | s_sda_low);

  twmsp_top uut (.ref_clk(ref_clk), .reset_n(reset_n), .cfg(cfg), .scl_i(scl_w), .scl_o(),
    .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_ready(cmd_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .evt(evt), .stat(stat),
    .irq(irq), .wake(wake));
  twmsp_slave_model #(.ADDR(SLV_ADDR)) peer (.scl(scl_w), .sda(sda_w), .sda_low(s_sda_low),
    .last_byte(last_byte), .got_stop(got_stop));

  // Clock, 8 ns
  initial forever #4 ref_clk = ~ref_clk;
  // Sticky copies of pulses: cmd error, start, hit, nack, irq, wake
  always @(posedge ref_clk) begin
    if (seen_clr) seen <= '0;
    else seen <= seen | {evt.cmd_err, evt.start_seen, evt.addr_hit, evt.nack_seen, irq, wake};
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic summarize();
    $display("tests %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic clear_seen();
    seen_clr = 1'b1;
    tick(1);
    seen_clr = 1'b0;
  endtask
  task automatic hang(input string what);
    n_errors++;
    $display("MISMATCH at %0t: %s timed out", $time, what);
    summarize();
  endtask
  task automatic wait_ready();
    int i;
    for (i = 0; i < 4000 && cmd_ready !== 1'b1; i++) tick(1);
    if (i == 4000) hang("cmd_ready");
  endtask
  // One master command, held until taken, then wait for completion
  task automatic issue(input twmsp_pkg::twmsp_op_t op, input logic [7:0] d);
    wait_ready();
    cmd = '{op: op, data: d, nack: 1'b0};
    cmd_valid = 1'b1;
    tick(1);
    cmd_valid = 1'b0;
    tick(2);
    wait_ready();
  endtask
  // Foreign master, 80 ns bit time; honours stretching
  task automatic scl_up();
    int i;
    m_scl_low = 1'b0;
    for (i = 0; i < 3000 && scl_w !== 1'b1; i++) tick(1);
    if (i == 3000) hang("scl stretch");
    tick(5);
  endtask
  task automatic xbit(input logic b, output logic rd);
    m_scl_low = 1'b1;
    tick(2);
    m_sda_low = !b;
    tick(3);
    scl_up();
    rd = sda_w;
  endtask
  task automatic xbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(b[i], r);
    xbit(1'b1, r);
    ack = !r;
  endtask
  task automatic xstart(input logic [7:0] a, output logic ack);
    m_sda_low = 1'b1;
    tick(5);
    xbyte(a, ack);
  endtask
  task automatic xstop();
    logic r;
    xbit(1'b0, r);
    m_sda_low = 1'b0;
    tick(5);
  endtask
  task automatic pop(input logic [7:0] exp);
    int i;
    for (i = 0; i < 100 && rx_valid !== 1'b1; i++) tick(1);
    if (i == 100) hang("rx_valid");
    check(rx_data, exp, "received byte");
    rx_ready = 1'b1;
    tick(1);
    rx_ready = 1'b0;
    tick(1);
  endtask

  // Master: refused address, repeated start, write, stop
  task automatic test_master();
    cfg = '{slave_en: 1'b0, master_en: 1'b1, irq_en: 1'b0, own_addr: OWN_ADDR};
    clear_seen();
    issue(twmsp_pkg::OP_STOP, 8'h00);
    check({7'h00, seen[5]}, 8'h01, "stray op refused in idle");
    issue(twmsp_pkg::OP_START, 8'h00);
    check({4'h0, stat}, 8'h0C, "busy and owned");
    issue(twmsp_pkg::OP_WRITE, {SLV_ADDR + 7'h01, 1'b0});
    check({7'h00, seen[2]}, 8'h01, "nack on foreign address");
    clear_seen();
    issue(twmsp_pkg::OP_START, 8'h00);
    issue(twmsp_pkg::OP_WRITE, {SLV_ADDR, 1'b0});
    issue(twmsp_pkg::OP_WRITE, 8'hC3);
    issue(twmsp_pkg::OP_STOP, 8'h00);
    check({7'h00, seen[2]}, 8'h00, "nack on good address");
    check(last_byte, 8'hC3, "byte at partner");
    check({7'h00, got_stop}, 8'h01, "stop issued");
    check({4'h0, stat}, 8'h00, "bus freed");
    $display("test master done");
  endtask
  // Slave receive until the buffer refuses, then drain
  task automatic test_slave_rx();
    logic ack;
    int i;
    cfg = '{slave_en: 1'b1, master_en: 1'b0, irq_en: 1'b1, own_addr: OWN_ADDR};
    clear_seen();
    xstart({OWN_ADDR, 1'b0}, ack);
    check({7'h00, ack}, 8'h01, "own address ack");
    check({2'h0, seen}, 8'h1B, "address events");
    for (i = 0; i < 16; i++) begin
      xbyte(8'h40 + 8'(i), ack);
      check({7'h00, ack}, 8'h01, "data ack");
    end
    fork
      xbyte(8'h50, ack);
      begin
        tick(400);
        check({7'h00, scl_oe}, 8'h01, "stretch when full");
        for (i = 0; i < 17; i++) pop(8'h40 + 8'(i));
      end
    join
    xstop();
    $display("test slave_rx done");
  endtask
  // Slave transmit: read addressed, one byte, then master NACK
  task automatic test_slave_tx();
    logic ack, r;
    logic [7:0] d;
    d = 8'h00;
    clear_seen();
    tx_data = 8'hA5;
    tx_valid = 1'b1;
    xstart({OWN_ADDR, 1'b1}, ack);
    check({7'h00, ack}, 8'h01, "read address ack");
    check({4'h0, stat}, 8'h0B, "slave read status");
    for (int i = 0; i < 8; i++) begin
      xbit(1'b1, r);
      d = {d[6:0], r};
    end
    tx_valid = 1'b0;
    xbit(1'b1, r);
    xstop();
    check(d, 8'hA5, "slave sent byte");
    check({7'h00, seen[2]}, 8'h01, "master nack seen");
    $display("test slave_tx done");
  endtask
  // Foreign address, then master-only with a foreign start
  task automatic test_foreign();
    logic ack;
    clear_seen();
    xstart({OWN_ADDR + 7'h01, 1'b0}, ack);
    xstop();
    check({7'h00, ack}, 8'h00, "other address ack");
    check({7'h00, seen[0]}, 8'h00, "wake on miss");
    cfg = '{slave_en: 1'b0, master_en: 1'b1, irq_en: 1'b1, own_addr: OWN_ADDR};
    clear_seen();
    xstart({OWN_ADDR, 1'b0}, ack);
    xstop();
    check({2'h0, seen}, 8'h00, "events master only");
    $display("test foreign done");
  endtask

  initial begin
    tick(4);
    reset_n = 1'b1;
    tick(10);
    test_master();
    test_slave_rx();
    test_slave_tx();
    test_foreign();
    summarize();
  end
endmodule // twmsp_tb_top
